// file: bench/hjm_host.sv
/*
 Host bus master model: 800 ns bus clock, open-drain data.
 Assumes a pulled-up data wire resolved by the bench.
*/
module hjm_host (
    // Clock
    input wire logic clk,
    // Bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data moves mid-low, sampled at the end of the high phase
    task automatic bit_x(input logic b, output logic r);
        sda_pull = !b;
        hold(2);
        scl = 1'b1;
        hold(4);
        r = sda;
        scl = 1'b0;
        hold(2);
    endtask
    // Long low first so a target's ack is gone before restart
    task automatic start();
        sda_pull = 1'b0;
        hold(6);
        scl = 1'b1;
        hold(4);
        sda_pull = 1'b1;
        hold(4);
        scl = 1'b0;
        hold(2);
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        hold(2);
        scl = 1'b1;
        hold(4);
        sda_pull = 1'b0;
        hold(4);
    endtask
    task automatic xfer(input logic [7:0] b, input logic m,
                        output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
            r[i] = s;
        end
        bit_x(m, s);
        ack = !s;
    endtask
    // Pointer, then one data byte or a one-byte read ended by nack
    task automatic access(input logic [6:0] dev, input logic wr,
        input logic [7:0] p, input logic [7:0] wd,
        output logic [7:0] rd, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2, x;
        start();
        xfer({dev, 1'b0}, 1'b1, r, a0);
        xfer(p, 1'b1, r, a1);
        if (wr) begin
            xfer(wd, 1'b1, r, a2);
        end else begin
            start();
            xfer({dev, 1'b1}, 1'b1, r, a2);
            xfer(8'hff, 1'b1, rd, x);
        end
        stop();
        ok = a0 && a1 && a2;
    endtask
endmodule // hjm_host

// file: bench/hjm_seq_asserts.sv
/*
 Port checker for the joystick measurement sequencer.
 Assumes binding to hjm_seq with the same shortened counts.
*/
module hjm_seq_asserts #(
    parameter int STARTUP_CYC = 50,
    parameter int CONV_CYC = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins
    input wire logic addr_sel,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq_out_low,
    input wire logic irq_oe,
    // Front end
    input wire logic [7:0] x_sample,
    input wire logic [7:0] y_sample,
    input wire logic meas_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] since_rst, busy_len, since_meas;
    logic seen;
    // Counters; since_rst and since_meas saturate so long waits never wrap, busy_len clears when idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_rst <= 16'h0000;
            busy_len <= 16'h0000;
            since_meas <= 16'hffff;
            seen <= 1'b0;
        end else begin
            if (since_rst != 16'hffff) since_rst <= since_rst + 16'h0001;
            busy_len <= meas_busy ? busy_len + 16'h0001 : 16'h0000;
            if (meas_busy) since_meas <= 16'h0000;
            else if (since_meas != 16'hffff)
                since_meas <= since_meas + 16'h0001;
            if (meas_busy) seen <= 1'b1;
        end
    end
    sequence s_first_busy;
        $rose(meas_busy) && !seen;
    endsequence
    sequence s_irq_set;
        $rose(irq_oe);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        !arst_n |-> !irq_oe && !sda_oe && !meas_busy)
        else $error("outputs active in reset");
    a_irq_drive_low: assert property (irq_out_low == 1'b0)
        else $error("interrupt pin driven high");
    a_sda_drive_low: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_startup_irq_off: assert property (!seen |-> !irq_oe)
        else $error("interrupt during start-up");
    a_startup_busy_late: assert property (
        s_first_busy |-> since_rst >= STARTUP_CYC - 2)
        else $error("start-up too short");
    a_first_meas_due: assert property (
        since_rst == STARTUP_CYC + 4 |-> seen || meas_busy)
        else $error("no measurement after start-up");
    a_conv_bounded: assert property (
        meas_busy |-> busy_len <= CONV_CYC)
        else $error("measurement too long");
    a_irq_after_meas: assert property (
        s_irq_set |-> since_meas inside {[1:5]})
        else $error("interrupt not tied to measurement");
endmodule // hjm_seq_asserts

bind hjm_seq hjm_seq_asserts #(.STARTUP_CYC(STARTUP_CYC),
    .CONV_CYC(CONV_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
    .addr_sel(addr_sel), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_low(irq_out_low),
    .irq_oe(irq_oe), .x_sample(x_sample), .y_sample(y_sample),
    .meas_busy(meas_busy));

// file: bench/testbench.sv
/*
 Self-checking bench for hjm_seq with shortened counts.
 Assumes the host model on the bus and bench-driven samples.
*/
`define CHK(a, e) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        fail_count++; \
        $display("wrong value at %0t: got %h expected %h", \
            $time, (a), (e)); \
    end \
end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 50;
    localparam int CC = 20;
    localparam int CPM = 10;
    localparam logic [6:0] BASE = 7'h40; // arbitrary bus address
    logic clk = 1'b0;
    logic arst_n, addr_sel, w, ok;
    logic [7:0] x_smp, y_smp, d, a, wd, e;
    int n, cyc = 0, fail_count = 0, checks_done = 0;
    int tb_ms[8] = '{20, 40, 80, 100, 140, 200, 260, 320};
    logic [24:0] rows [12] = '{
        {1'b0, 8'h0f, 8'h00, 8'hf1}, {1'b0, 8'h12, 8'h00, 8'h05},
        {1'b0, 8'h13, 8'h00, 8'hfb}, {1'b0, 8'h14, 8'h00, 8'h05},
        {1'b0, 8'h15, 8'h00, 8'hfb}, {1'b0, 8'h2b, 8'h00, 8'h00},
        {1'b1, 8'h2b, 8'h5a, 8'h5a}, {1'b1, 8'h2c, 8'ha5, 8'ha5},
        {1'b1, 8'h2d, 8'h3c, 8'h3c}, {1'b1, 8'h10, 8'hff, 8'h12},
        {1'b0, 8'h3f, 8'h00, 8'h00}, {1'b1, 8'h12, 8'h07, 8'h07}};
    wire scl, pull, sda_oe, sda_out, irq_oe, irq_low, busy;
    // Pull-ups on both open-drain wires
    wire sda = !pull && (sda_oe ? sda_out : 1'b1);
    wire irq_n = irq_oe ? irq_low : 1'b1;

    hjm_seq #(.STARTUP_CYC(SC), .CONV_CYC(CC), .CYC_PER_MS(CPM),
        .I2C_BASE(BASE)) u_dut (.clk(clk), .arst_n(arst_n),
        .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_low(irq_low),
        .irq_oe(irq_oe), .x_sample(x_smp), .y_sample(y_smp),
        .meas_busy(busy));
    hjm_host u_host (.clk(clk), .scl(scl), .sda_pull(pull), .sda(sda));

    always #50 clk = ~clk;

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic acc(input logic wr, input logic [7:0] p,
                       input logic [7:0] v);
        u_host.access({BASE[6:1], addr_sel}, wr, p, v, d, ok);
    endtask
    task automatic wait_for(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 5000) begin
            @(negedge clk);
            k++;
        end
    endtask
    // Rest of start-up, one measurement, interrupt settles
    task automatic settle();
        wait_for(1'b1);
        wait_for(1'b0);
        repeat (4) @(negedge clk);
    endtask

    initial begin
        arst_n = 1'b0;
        addr_sel = 1'b1;
        x_smp = 8'h12;
        y_smp = 8'h34;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        settle();
        `CHK(irq_n, 1'b0)
        foreach (rows[i]) begin
            {w, a, wd, e} = rows[i];
            if (w) acc(1'b1, a, wd);
            acc(1'b0, a, 8'h00);
            `CHK(d, e)
        end
        acc(1'b0, 8'h11, 8'h00);
        `CHK(d, y_smp)
        `CHK(irq_n, 1'b1)
        `CHK(busy, 1'b1)
        settle();
        `CHK(irq_n, 1'b0)
        u_host.access({BASE[6:1], !addr_sel}, 1'b0, 8'h11, 8'h00, d, ok);
        `CHK(ok, 1'b0)
        `CHK(irq_n, 1'b0)
        // Dead zone edge: x equal to the limit, then one past it
        x_smp = 8'h07;
        y_smp = 8'h00;
        acc(1'b1, 8'h0f, 8'hf4);
        acc(1'b0, 8'h11, 8'h00);
        settle();
        `CHK(irq_n, 1'b1)
        x_smp = 8'h08;
        acc(1'b0, 8'h11, 8'h00);
        settle();
        `CHK(irq_n, 1'b0)
        acc(1'b1, 8'h0f, 8'hfc);
        repeat (4) @(negedge clk);
        `CHK(irq_n, 1'b1)
        acc(1'b0, 8'h11, 8'h00);
        settle();
        `CHK(irq_n, 1'b1)
        acc(1'b1, 8'h0f, 8'h02);
        `CHK(irq_n, 1'b1)
        settle();
        acc(1'b0, 8'h2b, 8'h00);
        `CHK(d, 8'h00)
        acc(1'b0, 8'h0f, 8'h00);
        `CHK(d, 8'hf1)
        // Every timebase code, wait measured from end to next start
        foreach (tb_ms[c]) begin
            acc(1'b1, 8'h0f, {1'b0, c[2:0], 4'h0});
            wait_for(1'b1);
            wait_for(1'b0);
            n = 0;
            while (busy !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            // Deviation from the nominal period, in cycles
            n = n - tb_ms[c] * CPM;
            `CHK(n > -4 && n < 4, 1'b1)
        end
        // Mid-run reset pulse of 200 ns, strap changed meanwhile
        addr_sel = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(irq_n, 1'b1)
        `CHK(sda, 1'b1)
        arst_n = 1'b1;
        settle();
        u_host.access({BASE[6:1], 1'b1}, 1'b0, 8'h10, 8'h00, d, ok);
        `CHK(ok, 1'b0)
        acc(1'b0, 8'h10, 8'h00);
        `CHK(ok, 1'b1)
        `CHK(d, x_smp)
        complete_run();
    end
endmodule // testbench

// file: core/hjm_seq.v
/*
 Measurement sequencer, register file and I2C target of a Hall
 joystick sensor. Assumes a 10 MHz clk, arst_n wired to the reset
 pin, x_sample/y_sample from a front end on the same clock, and
 pull-ups on the bus and interrupt wires outside.
*/
`include "hjm_defines.vh"

module hjm_seq #(
    parameter STARTUP_CYC = `HJM_STARTUP_CYC,
    parameter CONV_CYC = `HJM_CONV_CYC,
    parameter CYC_PER_MS = `HJM_CYC_PER_MS,
    parameter [6:0] I2C_BASE = `HJM_I2C_BASE
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Address strap
    input wire addr_sel,
    // I2C pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // Interrupt pin
    output wire irq_out_low,
    output reg irq_oe,
    // Front end
    input wire [7:0] x_sample,
    input wire [7:0] y_sample,
    output wire meas_busy
);

    // Sequencer states
    localparam [2:0] ST_START = 3'b001;
    localparam [2:0] ST_MEAS = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;
    // Bus states
    localparam [6:0] I_IDLE = 7'b0000001;
    localparam [6:0] I_ADDR = 7'b0000010;
    localparam [6:0] I_AACK = 7'b0000100;
    localparam [6:0] I_WR = 7'b0001000;
    localparam [6:0] I_WACK = 7'b0010000;
    localparam [6:0] I_RD = 7'b0100000;
    localparam [6:0] I_RACK = 7'b1000000;
    // Control reset value, upper six bits kept in ctrl_hi
    localparam [7:0] CTRL_RST = `HJM_CTRL_RST;

    reg [2:0] sync1;
    reg [2:0] sync2;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [31:0] cnt;
    reg [1:0] strap_cnt;
    reg addr_lsb;
    reg [5:0] ctrl_hi;
    reg valid;
    reg [7:0] x_pos;
    reg [7:0] y_pos;
    reg [7:0] xp;
    reg [7:0] xn;
    reg [7:0] yp;
    reg [7:0] yn;
    reg [7:0] curve_a;
    reg [7:0] curve_b;
    reg [7:0] curve_c;
    reg irq_set;
    reg [6:0] istate;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] tx;
    reg [7:0] ptr;
    reg rw;
    reg got_ptr;
    reg rack;
    reg y_hit;
    reg wr_stb;
    reg [7:0] wr_addr;
    reg [7:0] wr_data;
    reg y_read;
    reg [7:0] rd_byte;

    wire s_scl = sync2[0];
    wire s_sda = sync2[1];
    wire s_addr = sync2[2];
    wire scl_rise = s_scl & ~scl_d;
    wire scl_fall = ~s_scl & scl_d;
    wire bus_start = s_scl & scl_d & sda_d & ~s_sda;
    wire bus_stop = s_scl & scl_d & ~sda_d & s_sda;
    wire idle_mode = ctrl_hi[`HJM_CB_IDLE - 2];
    wire int_dis = ctrl_hi[`HJM_CB_INT_DIS - 2];
    wire int_fn = ctrl_hi[`HJM_CB_INT_FN - 2];
    wire [2:0] tb_code = ctrl_hi[`HJM_CB_TB_HI - 2:`HJM_CB_TB_LO - 2];
    wire soft_req = wr_stb & (wr_addr == `HJM_REG_CTRL)
        & wr_data[`HJM_CB_SOFT];
    wire [31:0] tb_cyc = tb_ms(tb_code) * CYC_PER_MS;
    wire [6:0] my_addr = {I2C_BASE[6:1], addr_lsb};

    // Timebase code to interval in ms
    function [8:0] tb_ms;
        input [2:0] code;
        begin
            case (code)
                3'h0: tb_ms = `HJM_TB0_MS;
                3'h1: tb_ms = `HJM_TB1_MS;
                3'h2: tb_ms = `HJM_TB2_MS;
                3'h3: tb_ms = `HJM_TB3_MS;
                3'h4: tb_ms = `HJM_TB4_MS;
                3'h5: tb_ms = `HJM_TB5_MS;
                3'h6: tb_ms = `HJM_TB6_MS;
                default: tb_ms = `HJM_TB7_MS;
            endcase
        end
    endfunction

    // Dead-zone test on signed coordinates
    function outside;
        input [7:0] xs;
        input [7:0] ys;
        begin
            outside = ($signed(xs) > $signed(xp))
                | ($signed(xs) < $signed(xn))
                | ($signed(ys) > $signed(yp))
                | ($signed(ys) < $signed(yn));
        end
    endfunction

    // [R2] Open drain, low only
    assign irq_out_low = 1'b0;
    // [R4] Data line never driven high
    assign sda_out = 1'b0;
    assign meas_busy = state[1];

    // Pin synchronisers; first stage feeds only the second
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // Bus lines reset to idle high: no false edge after reset
            sync1 <= 3'h3;
            sync2 <= 3'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= {addr_sel, sda_in, scl_in};
            sync2 <= sync1;
            scl_d <= s_scl;
            sda_d <= s_sda;
        end
    end

    // Register read mux; unmapped reads as zero
    always @* begin
        case (ptr)
            `HJM_REG_CTRL: rd_byte = {ctrl_hi, state[0], valid};
            `HJM_REG_X: rd_byte = x_pos;
            `HJM_REG_Y: rd_byte = y_pos;
            `HJM_REG_XP: rd_byte = xp;
            `HJM_REG_XN: rd_byte = xn;
            `HJM_REG_YP: rd_byte = yp;
            `HJM_REG_YN: rd_byte = yn;
            `HJM_REG_CA: rd_byte = curve_a;
            `HJM_REG_CB: rd_byte = curve_b;
            `HJM_REG_CC: rd_byte = curve_c;
            default: rd_byte = 8'h00;
        endcase
    end

    // [R13] I2C target engine, answers own address only
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            istate <= I_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            got_ptr <= 1'b0;
            rack <= 1'b0;
            y_hit <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            y_read <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            y_read <= 1'b0;
            if (bus_start) begin
                istate <= I_ADDR;
                bitcnt <= 4'h0;
                got_ptr <= 1'b0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                istate <= I_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (istate)
                    I_ADDR, I_WR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], s_sda};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (istate == I_WR) begin
                                istate <= I_WACK;
                                sda_oe <= 1'b1;
                                if (!got_ptr) begin
                                    ptr <= shreg;
                                    got_ptr <= 1'b1;
                                end else begin
                                    wr_stb <= 1'b1;
                                    wr_addr <= ptr;
                                    wr_data <= shreg;
                                    ptr <= ptr + 8'h01;
                                end
                            // [R13] Foreign address: stay silent
                            end else if (shreg[7:1] == my_addr) begin
                                istate <= I_AACK;
                                sda_oe <= 1'b1;
                                rw <= shreg[0];
                            end else begin
                                istate <= I_IDLE;
                            end
                        end
                    end
                    I_AACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                istate <= I_RD;
                                tx <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                            end else begin
                                istate <= I_WR;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    I_WACK: begin
                        if (scl_fall) begin
                            istate <= I_WR;
                            sda_oe <= 1'b0;
                        end
                    end
                    I_RD: begin
                        if (scl_rise) begin
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                istate <= I_RACK;
                                bitcnt <= 4'h0;
                                sda_oe <= 1'b0;
                            end else begin
                                tx <= {tx[6:0], 1'b0};
                                sda_oe <= ~tx[6];
                            end
                        end
                    end
                    I_RACK: begin
                        if (scl_rise) begin
                            rack <= ~s_sda;
                            y_hit <= (ptr == `HJM_REG_Y);
                            ptr <= ptr + 8'h01;
                        end else if (scl_fall) begin
                            // [R15] Y read ends with its ack bit
                            y_read <= y_hit;
                            if (rack) begin
                                istate <= I_RD;
                                tx <= rd_byte;
                                sda_oe <= ~rd_byte[7];
                            end else begin
                                istate <= I_IDLE;
                            end
                        end
                    end
                    default: istate <= I_IDLE;
                endcase
            end
        end
    end

    // [R1] [R5] Async reset lands in start-up
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_START;
            cnt <= 32'h0;
            strap_cnt <= 2'h0;
            addr_lsb <= 1'b0;
            ctrl_hi <= CTRL_RST[7:2];
            valid <= 1'b0;
            x_pos <= 8'h00;
            y_pos <= 8'h00;
            xp <= `HJM_XP_RST;
            xn <= `HJM_XN_RST;
            yp <= `HJM_YP_RST;
            yn <= `HJM_YN_RST;
            curve_a <= `HJM_CURVE_RST;
            curve_b <= `HJM_CURVE_RST;
            curve_c <= `HJM_CURVE_RST;
            irq_set <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            // [R14] [R18] Released in start-up or when disabled
            irq_oe <= irq_set & ~int_dis & ~state[0];
            // [R18] Y read clears; a same-cycle set wins below
            if (y_read) begin
                irq_set <= 1'b0;
            end
            // [R3] Strap caught once synchroniser holds it
            if (strap_cnt != 2'h3) begin
                strap_cnt <= strap_cnt + 2'h1;
                if (strap_cnt == 2'h2) begin
                    addr_lsb <= s_addr;
                end
            end
            // [R6] Soft reset restarts like a hardware reset
            if (soft_req) begin
                state <= ST_START;
                cnt <= 32'h0;
                strap_cnt <= 2'h0;
                irq_set <= 1'b0;
            end else begin
                if (wr_stb && !state[0]) begin
                    case (wr_addr)
                        `HJM_REG_CTRL: ctrl_hi <= wr_data[7:2];
                        `HJM_REG_XP: xp <= wr_data;
                        `HJM_REG_XN: xn <= wr_data;
                        `HJM_REG_YP: yp <= wr_data;
                        `HJM_REG_YN: yn <= wr_data;
                        // [R12] Curve parameters from the host
                        `HJM_REG_CA: curve_a <= wr_data;
                        `HJM_REG_CB: curve_b <= wr_data;
                        `HJM_REG_CC: curve_c <= wr_data;
                        default: ;
                    endcase
                end
                case (state)
                    ST_START: begin
                        // [R7] Registers held at reset values
                        ctrl_hi <= CTRL_RST[7:2];
                        valid <= 1'b0;
                        x_pos <= 8'h00;
                        y_pos <= 8'h00;
                        xp <= `HJM_XP_RST;
                        xn <= `HJM_XN_RST;
                        yp <= `HJM_YP_RST;
                        yn <= `HJM_YN_RST;
                        curve_a <= `HJM_CURVE_RST;
                        curve_b <= `HJM_CURVE_RST;
                        curve_c <= `HJM_CURVE_RST;
                        irq_set <= 1'b0;
                        // [R8] Full start-up time, then measure
                        if (cnt == STARTUP_CYC - 1) begin
                            state <= ST_MEAS;
                            cnt <= 32'h0;
                        end else begin
                            cnt <= cnt + 32'h1;
                        end
                    end
                    ST_MEAS: begin
                        // [R9] Results stored at end of conversion
                        if (cnt == CONV_CYC - 1) begin
                            x_pos <= x_sample;
                            y_pos <= y_sample;
                            valid <= 1'b1;
                            // [R10] [R17] Mode picks when to flag
                            if (!int_fn || outside(x_sample, y_sample)) begin
                                irq_set <= 1'b1;
                            end
                            state <= ST_WAIT;
                            cnt <= 32'h0;
                        end else begin
                            cnt <= cnt + 32'h1;
                        end
                    end
                    ST_WAIT: begin
                        // [R11] [R15] [R16] Host-paced or timed wake
                        if (idle_mode) begin
                            cnt <= 32'h0;
                            if (y_read) begin
                                state <= ST_MEAS;
                                valid <= 1'b0;
                            end
                        end else if (cnt >= tb_cyc - 32'h1) begin
                            state <= ST_MEAS;
                            valid <= 1'b0;
                            cnt <= 32'h0;
                        end else begin
                            cnt <= cnt + 32'h1;
                        end
                    end
                    default: state <= ST_START;
                endcase
            end
        end
    end

endmodule // hjm_seq

// file: shared/hjm_defines.vh
/*
 Constants for the Hall joystick measurement sequencer: register
 offsets, field positions, reset values and timing counts.
 Assumes a 10 MHz core clock; included by core/hjm_seq.v only.
*/
// What this block does
// [R1] Reset input low holds all logic reset
// [R2] Interrupt pin: open drain, driven low only
// [R3] Address select pin captured at every reset
// [R4] Data line only pulled low or released
// [R5] Reset pulse over 100 ns enters start-up
// [R6] Control bit 1 soft reset enters start-up
// [R7] Start-up loads every register's reset value
// [R8] Start-up 1000 us, one measurement, then wait
// [R9] Coordinates stored within 450 us of start
// [R10] After measurement, interrupt set per bits 2,3
// [R11] Wait trigger chosen by bit 7, bits 6:4
// [R12] Host writes curve parameters during initialisation
// [R13] Target only; ignore non-matching addresses
// [R14] Interrupt released in reset and start-up
// [R15] Host-paced: measure after Y read acknowledge
// [R16] Timed mode repeats at 20..320 ms steps
// [R17] Interrupt every measurement, or outside dead zone
// [R18] Y read releases interrupt; disable forces release
`ifndef HJM_DEFINES_VH
`define HJM_DEFINES_VH

// Register offsets
`define HJM_REG_CTRL 8'h0f
`define HJM_REG_X 8'h10
`define HJM_REG_Y 8'h11
`define HJM_REG_XP 8'h12
`define HJM_REG_XN 8'h13
`define HJM_REG_YP 8'h14
`define HJM_REG_YN 8'h15
`define HJM_REG_CA 8'h2b
`define HJM_REG_CB 8'h2c
`define HJM_REG_CC 8'h2d

// Reset values
`define HJM_CTRL_RST 8'hf0
`define HJM_XP_RST 8'h05
`define HJM_XN_RST 8'hfb
`define HJM_YP_RST 8'h05
`define HJM_YN_RST 8'hfb
`define HJM_CURVE_RST 8'h00

// Control fields
`define HJM_CB_IDLE 7
`define HJM_CB_TB_HI 6
`define HJM_CB_TB_LO 4
`define HJM_CB_INT_DIS 3
`define HJM_CB_INT_FN 2
`define HJM_CB_SOFT 1
`define HJM_CB_VALID 0

// Timing, in printed units
`define HJM_CLK_MHZ 10
`define HJM_RST_PULSE_NS 100
`define HJM_STARTUP_US 1000
`define HJM_CONV_US 450
`define HJM_TB0_MS 9'd20
`define HJM_TB1_MS 9'd40
`define HJM_TB2_MS 9'd80
`define HJM_TB3_MS 9'd100
`define HJM_TB4_MS 9'd140
`define HJM_TB5_MS 9'd200
`define HJM_TB6_MS 9'd260
`define HJM_TB7_MS 9'd320

// Cycle counts derived from the clock rate
`define HJM_STARTUP_CYC (`HJM_STARTUP_US * `HJM_CLK_MHZ)
`define HJM_CONV_CYC (`HJM_CONV_US * `HJM_CLK_MHZ)
`define HJM_CYC_PER_MS (1000 * `HJM_CLK_MHZ)

// Bus address, upper six bits (value arbitrary)
`define HJM_I2C_BASE 7'h40

`endif
